/* rtl/radio_cmd_params.svh */
// Named constants for the radio command host: opcodes, codes, timing.
// Assumes inclusion by bare name from the package; the host module only uses its macros.
`ifndef RADIO_CMD_PARAMS_SVH
`define RADIO_CMD_PARAMS_SVH

// Command opcodes
`define OP_IMAGE_CAL      8'h98
`define OP_AMP_SETUP      8'h95
`define OP_POST_STATE     8'h93
`define OP_MEM_WRITE      8'h0D
`define OP_MEM_READ       8'h1D
`define OP_PAYLOAD_STORE  8'h0E
`define OP_PAYLOAD_FETCH  8'h1E

// Amplifier setup fields
`define VARIANT_HIGH_POWER 8'h00
`define VARIANT_LOW_POWER  8'h01
`define AMP_TABLE_VALUE    8'h01
`define AMP_SIZE_MAX       8'h07
`define DUTY_MAX_LP_HIGH   8'h07
`define DUTY_MAX_LP_LOW    8'h04
`define DUTY_MAX_HP        8'h04

// Post-packet state codes
`define STATE_SYNTH_READY  8'h40
`define STATE_XTAL_STANDBY 8'h30
`define STATE_RC_STANDBY   8'h20

// Filler byte sent while the device answers
`define FILLER_BYTE        8'h00

// Header lengths in bytes, opcode included
`define HDR_LEN_CAL        3'h3
`define HDR_LEN_AMP        3'h5
`define HDR_LEN_STATE      3'h2
`define HDR_LEN_MEM        3'h3
`define HDR_LEN_BUF        3'h2

// Byte position of the status answer
`define STATUS_BYTE_IDX    1

// Serial clock timing
`define CLK_SYS_MHZ        100
`define SCLK_HALF_NS       80
`define SCLK_HALF_CYC      ((`SCLK_HALF_NS * `CLK_SYS_MHZ + 999) / 1000)

`endif

/* rtl/radio_cmd_pkg.sv */
// Types shared by the radio command host.
// Assumes the params header sits beside it in rtl/.
package radio_cmd_pkg;
    `include "radio_cmd_params.svh"

    // Commands that the user may order
    typedef enum logic [2:0] {
        KIND_IMAGE_CAL     = 3'h0,
        KIND_AMP_SETUP     = 3'h1,
        KIND_POST_STATE    = 3'h2,
        KIND_MEM_WRITE     = 3'h3,
        KIND_MEM_READ      = 3'h4,
        KIND_PAYLOAD_STORE = 3'h5,
        KIND_PAYLOAD_FETCH = 3'h6
    } cmd_kind_t;

    // Frame sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_SETUP = 6'h02,
        ST_LOAD  = 6'h04,
        ST_XFER  = 6'h08,
        ST_HOLD  = 6'h10,
        ST_GAP   = 6'h20
    } seq_state_t;
endpackage : radio_cmd_pkg

/* rtl/byte_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    // Depth must be a power of two for the pointer wrap
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("byte_fifo depth must be a power of two, 2 or more");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             push;
    logic             pop;

    // Full and empty from pointers with an extra wrap bit
    assign out_valid_o = (wr_ptr_reg != rd_ptr_reg);
    assign in_ready_o  = (wr_ptr_reg != {~rd_ptr_reg[AW], rd_ptr_reg[AW-1:0]});
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];

    // Storage
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule : byte_fifo

/* rtl/radio_cmd_host.sv */
// Host controller that frames radio commands on the serial bus.
// Assumes a mode-0 serial slave; miso arrives from outside and is synced.
`timescale 1ns/1ps

// Overview of operation
// - Image calibration sends 0x98 then the low and high band codes.
// - Amplifier setup sends 0x95 then duty, size, variant and table bytes.
// - The amplifier table byte is always sent as 0x01.
// - The amplifier size byte never goes above 0x07.
// - Duty is capped at 0x07 or 0x04 for low power by band, 0x04 else.
// - Post-packet state command sends 0x93 then one state code.
// - Memory write sends 0x0D, address high, address low, then data.
// - Memory read sends 0x1D, two address bytes, a filler, then data.
// - Payload store sends 0x0E, an offset, then payload bytes.
// - Payload fetch sends 0x1E, an offset, a filler, then data.
module radio_cmd_host
    import radio_cmd_pkg::*;
#(
    parameter int LEN_W = 8
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             cmd_valid_i,
    output logic                  cmd_ready_o,
    input  wire cmd_kind_t        cmd_kind_i,
    input  wire logic [7:0]       cmd_arg0_i,
    input  wire logic [7:0]       cmd_arg1_i,
    input  wire logic [7:0]       cmd_arg2_i,
    input  wire logic             band_above_400_i,
    input  wire logic [15:0]      cmd_addr_i,
    input  wire logic [LEN_W-1:0] cmd_len_i,
    input  wire logic [7:0]       wr_data_i,
    input  wire logic             wr_valid_i,
    output logic                  wr_ready_o,
    output logic      [7:0]       rd_data_o,
    output logic                  rd_valid_o,
    output logic      [7:0]       status_o,
    output logic      [15:0]      next_addr_o,
    output logic      [7:0]       post_packet_state_o,
    output logic                  done_o,
    output logic                  refused_o,
    output logic                  spi_sclk_o,
    output logic                  spi_mosi_o,
    output logic                  spi_cs_n_o,
    input  wire logic             spi_miso_i
);
    localparam int TOT_W  = LEN_W + 1;
    localparam int HALF   = `SCLK_HALF_CYC;
    localparam int HCNT_W = $clog2(HALF + 1);

    if (LEN_W < 1 || LEN_W > 12) begin : g_bad_len
        $error("radio_cmd_host LEN_W must lie in 1..12");
    end

    // Duty ceiling for the chosen amplifier path
    function automatic logic [7:0] duty_limit(input logic [7:0] variant,
                                              input logic above_400);
        if (variant == `VARIANT_LOW_POWER) begin
            duty_limit = above_400 ? `DUTY_MAX_LP_HIGH : `DUTY_MAX_LP_LOW;
        end else begin
            duty_limit = `DUTY_MAX_HP;
        end
    endfunction : duty_limit

    // Smaller of a value and its ceiling
    function automatic logic [7:0] clamp8(input logic [7:0] v,
                                          input logic [7:0] lim);
        clamp8 = (v > lim) ? lim : v;
    endfunction : clamp8

    seq_state_t       state_reg;
    cmd_kind_t        kind_reg;
    logic [7:0]       hdr_reg [5];
    logic [7:0]       hdr_next [5];
    logic [2:0]       hdr_len_reg;
    logic [2:0]       hdr_len_next;
    logic             legal;
    logic [TOT_W-1:0] total_reg;
    logic [TOT_W-1:0] idx_reg;
    logic [3:0]       bit_cnt_reg;
    logic [7:0]       tx_reg;
    logic [7:0]       rx_reg;
    logic [HCNT_W-1:0] half_cnt_reg;
    logic             tick;
    logic             sclk_reg;
    logic             cs_n_reg;
    logic             miso_meta_reg;
    logic             miso_sync_reg;
    logic [15:0]      addr_reg;
    logic [7:0]       post_reg;
    logic             cmd_fire;
    logic             is_write;
    logic             is_read;
    logic             is_buf;
    logic             in_data;
    logic             need_fifo;
    logic             fifo_pop;
    logic [7:0]       fifo_data;
    logic             fifo_valid;
    logic             byte_end;
    logic             last_byte;

    // Payload path for write commands
    byte_fifo #(.WIDTH(8), .DEPTH(8)) u_wr_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_data_i   (wr_data_i),
        .in_valid_i  (wr_valid_i),
        .in_ready_o  (wr_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    // Header bytes built from the user order
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            hdr_next[i] = `FILLER_BYTE;
        end
        hdr_len_next = `HDR_LEN_STATE;
        legal        = 1'b1;
        case (cmd_kind_i)
            KIND_IMAGE_CAL: begin
                hdr_next[0]  = `OP_IMAGE_CAL;
                hdr_next[1]  = cmd_arg0_i;
                hdr_next[2]  = cmd_arg1_i;
                hdr_len_next = `HDR_LEN_CAL;
            end
            KIND_AMP_SETUP: begin
                hdr_next[0]  = `OP_AMP_SETUP;
                hdr_next[1]  = clamp8(cmd_arg0_i,
                                      duty_limit(cmd_arg2_i,
                                                 band_above_400_i));
                hdr_next[2]  = clamp8(cmd_arg1_i, `AMP_SIZE_MAX);
                hdr_next[3]  = cmd_arg2_i;
                hdr_next[4]  = `AMP_TABLE_VALUE;
                hdr_len_next = `HDR_LEN_AMP;
                legal = (cmd_arg2_i == `VARIANT_HIGH_POWER) ||
                        (cmd_arg2_i == `VARIANT_LOW_POWER);
            end
            KIND_POST_STATE: begin
                hdr_next[0]  = `OP_POST_STATE;
                hdr_next[1]  = cmd_arg0_i;
                legal = (cmd_arg0_i == `STATE_SYNTH_READY) ||
                        (cmd_arg0_i == `STATE_XTAL_STANDBY) ||
                        (cmd_arg0_i == `STATE_RC_STANDBY);
            end
            KIND_MEM_WRITE, KIND_MEM_READ: begin
                hdr_next[0]  = (cmd_kind_i == KIND_MEM_WRITE) ?
                               `OP_MEM_WRITE : `OP_MEM_READ;
                hdr_next[1]  = cmd_addr_i[15:8];
                hdr_next[2]  = cmd_addr_i[7:0];
                hdr_len_next = `HDR_LEN_MEM;
            end
            KIND_PAYLOAD_STORE, KIND_PAYLOAD_FETCH: begin
                hdr_next[0]  = (cmd_kind_i == KIND_PAYLOAD_STORE) ?
                               `OP_PAYLOAD_STORE
                               : `OP_PAYLOAD_FETCH;
                hdr_next[1]  = cmd_addr_i[7:0];
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

    assign cmd_ready_o = (state_reg == ST_IDLE);
    assign cmd_fire    = cmd_valid_i && cmd_ready_o && legal;
    assign refused_o   = cmd_valid_i && cmd_ready_o && !legal;
    assign is_write    = (kind_reg == KIND_MEM_WRITE) ||
                         (kind_reg == KIND_PAYLOAD_STORE);
    assign is_read     = (kind_reg == KIND_MEM_READ) ||
                         (kind_reg == KIND_PAYLOAD_FETCH);
    assign is_buf      = (kind_reg == KIND_PAYLOAD_STORE) ||
                         (kind_reg == KIND_PAYLOAD_FETCH);
    assign in_data     = is_read ? (idx_reg > TOT_W'(hdr_len_reg))
                                 : (idx_reg >= TOT_W'(hdr_len_reg));
    assign need_fifo   = is_write && (idx_reg >= TOT_W'(hdr_len_reg));
    assign fifo_pop    = (state_reg == ST_LOAD) && need_fifo && fifo_valid;
    assign tick        = (half_cnt_reg == HCNT_W'(HALF - 1));
    assign byte_end    = (state_reg == ST_XFER) && tick && sclk_reg &&
                         (bit_cnt_reg == 4'h8);
    assign last_byte   = (idx_reg == total_reg - 1'b1);

    // Miso crosses into the system clock through two flops
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            miso_meta_reg <= 1'b0;
            miso_sync_reg <= 1'b0;
        end else begin
            miso_meta_reg <= spi_miso_i;
            miso_sync_reg <= miso_meta_reg;
        end
    end

    // Half-period divider, restarted while idle to align phases
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            half_cnt_reg <= '0;
        end else if (state_reg == ST_IDLE || tick) begin
            half_cnt_reg <= '0;
        end else begin
            half_cnt_reg <= half_cnt_reg + 1'b1;
        end
    end

    // Command latch
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            kind_reg    <= KIND_IMAGE_CAL;
            hdr_len_reg <= `HDR_LEN_STATE;
            total_reg   <= '0;
            for (int i = 0; i < 5; i++) begin
                hdr_reg[i] <= `FILLER_BYTE;
            end
        end else if (cmd_fire) begin
            kind_reg    <= cmd_kind_i;
            hdr_len_reg <= hdr_len_next;
            for (int i = 0; i < 5; i++) begin
                hdr_reg[i] <= hdr_next[i];
            end
            case (cmd_kind_i)
                KIND_MEM_WRITE, KIND_PAYLOAD_STORE: begin
                    total_reg <= TOT_W'(hdr_len_next) + TOT_W'(cmd_len_i);
                end
                KIND_MEM_READ, KIND_PAYLOAD_FETCH: begin
                    total_reg <= TOT_W'(hdr_len_next) + TOT_W'(cmd_len_i)
                                 + 1'b1;
                end
                default: begin
                    total_reg <= TOT_W'(hdr_len_next);
                end
            endcase
        end
    end

    // Frame sequencer and bit engine
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg   <= ST_IDLE;
            cs_n_reg    <= 1'b1;
            sclk_reg    <= 1'b0;
            tx_reg      <= `FILLER_BYTE;
            rx_reg      <= `FILLER_BYTE;
            bit_cnt_reg <= '0;
            idx_reg     <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    idx_reg <= '0;
                    if (cmd_fire) begin
                        cs_n_reg  <= 1'b0;
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (tick) begin
                        state_reg <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (!need_fifo || fifo_valid) begin
                        if (idx_reg < TOT_W'(hdr_len_reg)) begin
                            tx_reg <= hdr_reg[idx_reg[2:0]];
                        end else if (need_fifo) begin
                            tx_reg <= fifo_data;
                        end else begin
                            tx_reg <= `FILLER_BYTE;
                        end
                        bit_cnt_reg <= '0;
                        state_reg   <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (tick && !sclk_reg) begin
                        sclk_reg    <= 1'b1;
                        rx_reg      <= {rx_reg[6:0], miso_sync_reg};
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    end else if (tick) begin
                        sclk_reg <= 1'b0;
                        if (bit_cnt_reg == 4'h8) begin
                            idx_reg   <= idx_reg + 1'b1;
                            state_reg <= last_byte ? ST_HOLD : ST_LOAD;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                        end
                    end
                end
                ST_HOLD: begin
                    if (tick) begin
                        cs_n_reg  <= 1'b1;
                        state_reg <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (tick) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    cs_n_reg  <= 1'b1;
                    sclk_reg  <= 1'b0;
                end
            endcase
        end
    end

    // Answers: status, read data and the address the device now holds
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            status_o   <= `FILLER_BYTE;
            rd_data_o  <= `FILLER_BYTE;
            rd_valid_o <= 1'b0;
            addr_reg   <= '0;
        end else begin
            rd_valid_o <= 1'b0;
            if (cmd_fire) begin
                addr_reg <= cmd_addr_i;
            end
            if (byte_end && idx_reg == TOT_W'(`STATUS_BYTE_IDX)) begin
                status_o <= rx_reg;
            end
            if (byte_end && in_data && (is_read || is_write)) begin
                if (is_buf) begin
                    addr_reg <= {8'h00, addr_reg[7:0] + 8'h01};
                end else begin
                    addr_reg <= addr_reg + 16'h0001;
                end
                if (is_read) begin
                    rd_data_o  <= rx_reg;
                    rd_valid_o <= 1'b1;
                end
            end
        end
    end

    // Post-packet state the device now holds, RC standby from reset
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            post_reg <= `STATE_RC_STANDBY;
        end else if (state_reg == ST_HOLD && tick &&
                     kind_reg == KIND_POST_STATE) begin
            post_reg <= hdr_reg[1];
        end
    end

    assign done_o              = (state_reg == ST_HOLD) && tick;
    assign post_packet_state_o = post_reg;
    assign next_addr_o         = addr_reg;
    assign spi_sclk_o          = sclk_reg;
    assign spi_mosi_o          = tx_reg[7];
    assign spi_cs_n_o          = cs_n_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    AST_CAL_FRAME: assert property (
        cmd_fire && cmd_kind_i == KIND_IMAGE_CAL |=>
        hdr_reg[0] == `OP_IMAGE_CAL && hdr_len_reg == `HDR_LEN_CAL)
        else $error("image calibration header wrong");
    AST_AMP_FRAME: assert property (
        cmd_fire && cmd_kind_i == KIND_AMP_SETUP |=>
        hdr_reg[0] == `OP_AMP_SETUP && hdr_len_reg == `HDR_LEN_AMP)
        else $error("amplifier setup header wrong");
    AST_VARIANT_LEGAL: assert property (
        cmd_fire && cmd_kind_i == KIND_AMP_SETUP |=>
        hdr_reg[3] == `VARIANT_HIGH_POWER || hdr_reg[3] == `VARIANT_LOW_POWER)
        else $error("illegal amplifier variant sent");
    AST_TABLE_FIXED: assert property (
        cmd_fire && cmd_kind_i == KIND_AMP_SETUP |=>
        hdr_reg[4] == `AMP_TABLE_VALUE)
        else $error("amplifier table byte not fixed");
    AST_SIZE_CAP: assert property (
        cmd_fire && cmd_kind_i == KIND_AMP_SETUP |=>
        hdr_reg[2] <= `AMP_SIZE_MAX &&
        hdr_reg[2] == clamp8($past(cmd_arg1_i), `AMP_SIZE_MAX))
        else $error("amplifier size not capped");
    AST_DUTY_CAP: assert property (
        cmd_fire && cmd_kind_i == KIND_AMP_SETUP |=>
        hdr_reg[1] <= duty_limit(hdr_reg[3], $past(band_above_400_i)))
        else $error("duty setting above its ceiling");
    AST_STATE_CODE: assert property (
        $changed(post_reg) |->
        $past(state_reg) == ST_HOLD && $past(kind_reg) == KIND_POST_STATE)
        else $error("post-packet state changed without its command");
    AST_READ_AFTER_FILLER: assert property (
        rd_valid_o |-> is_read && $past(idx_reg) > TOT_W'(hdr_len_reg))
        else $error("read data taken before the filler byte");
    AST_ADDR_STEP: assert property (
        byte_end && in_data && is_write && !is_buf |=>
        addr_reg == $past(addr_reg) + 16'h0001)
        else $error("memory write address did not step");
    AST_BUF_WRAP: assert property (
        byte_end && in_data && is_buf && addr_reg[7:0] == 8'hFF |=>
        addr_reg[7:0] == 8'h00)
        else $error("payload offset did not wrap");
    AST_CS_FRAME: assert property (
        (state_reg == ST_XFER || spi_sclk_o) |-> !spi_cs_n_o)
        else $error("chip select high during a byte");
endmodule : radio_cmd_host

/* testbench/radio_dev_model.sv */
// Behavioural radio device answering the host on the serial bus.
// Assumes mode 0: sample on sclk rise, shift on fall, cs low per command.
`timescale 1ns/1ps
module radio_dev_model #(
    parameter logic [7:0] STATUS = 8'h5A
) (
    input  wire logic sclk_i,
    input  wire logic mosi_i,
    input  wire logic cs_n_i,
    output logic      miso_o
);
    logic [7:0]  par [0:7];
    logic [7:0]  mem [logic [15:0]];
    logic [7:0]  pay [0:255];
    logic [7:0]  state = 8'h20;
    logic [7:0]  sr;
    logic [7:0]  tx;
    logic [15:0] adr;
    int          nbit;
    int          nbyte;

    // Frame start sends the reserved byte; a released line is inverted
    always @(negedge cs_n_i) begin
        nbit = 0;
        nbyte = 0;
        tx = 8'h00;
        miso_o = tx[7];
    end
    always @(posedge cs_n_i) miso_o = ~miso_o;

    // Next answer bit goes out on the falling edge
    always @(negedge sclk_i) if (!cs_n_i) miso_o = tx[7-nbit];

    // Take a byte on the rising edge and act on it
    always @(posedge sclk_i) if (!cs_n_i) begin
        sr = {sr[6:0], mosi_i};
        nbit++;
        if (nbit == 8) begin
            nbit = 0;
            if (nbyte < 8) par[nbyte] = sr;
            if (par[0] == 8'h93 && nbyte == 1) state = sr;
            if (nbyte == 1) adr = (par[0][3:0] == 4'hD) ? {sr, 8'h00} : sr;
            if (nbyte == 2 && par[0][3:0] == 4'hD) adr[7:0] = sr;
            if (par[0] == 8'h0D && nbyte >= 3) begin
                mem[adr] = sr;
                adr++;
            end
            if (par[0] == 8'h0E && nbyte >= 2) begin
                pay[adr[7:0]] = sr;
                adr[7:0]++;
            end
            nbyte++;
            tx = STATUS;
            if (par[0] == 8'h1D && nbyte >= 4) begin
                tx = mem[adr];
                adr++;
            end
            if (par[0] == 8'h1E && nbyte >= 3) begin
                tx = pay[adr[7:0]];
                adr[7:0]++;
            end
        end
    end
endmodule : radio_dev_model

/* testbench/radio_cmd_host_bench.sv */
// Self-checking bench: user orders into the host, device model behind it.
// Assumes the design package and the device model are compiled first.
`timescale 1ns/1ps
module radio_cmd_host_bench;
    import radio_cmd_pkg::*;
    localparam logic [7:0] STATUS = 8'h5A;
    logic clk_sys_i = 0, rst_i = 1, cmd_valid_i = 0, band_above_400_i = 0;
    logic wr_valid_i = 0, cmd_ready_o, wr_ready_o, rd_valid_o, done_o, refd;
    logic refused_o, spi_sclk_o, spi_mosi_o, spi_cs_n_o, spi_miso_i;
    cmd_kind_t   cmd_kind_i = KIND_IMAGE_CAL;
    logic [7:0]  cmd_arg0_i = 0, cmd_arg1_i = 0, cmd_arg2_i = 0;
    logic [7:0]  wr_data_i = 0, cmd_len_i = 0, rd_data_o, status_o;
    logic [7:0]  post_packet_state_o, got [$];
    logic [15:0] cmd_addr_i = 0, next_addr_o;
    logic [7:0]  dat [3] = '{8'h11, 8'h22, 8'h33};
    logic [7:0]  codes [3] = '{8'h40, 8'h20, 8'h30};
    int          n_mismatch = 0, checks_done = 0;

    radio_cmd_host #(.LEN_W(8)) dut (.clk_sys_i, .rst_i, .cmd_valid_i,
        .cmd_ready_o, .cmd_kind_i, .cmd_arg0_i, .cmd_arg1_i, .cmd_arg2_i,
        .band_above_400_i, .cmd_addr_i, .cmd_len_i, .wr_data_i, .wr_valid_i,
        .wr_ready_o, .rd_data_o, .rd_valid_o, .status_o, .next_addr_o,
        .post_packet_state_o, .done_o, .refused_o, .spi_sclk_o, .spi_mosi_o,
        .spi_cs_n_o, .spi_miso_i);
    radio_dev_model #(.STATUS(STATUS)) dev (.sclk_i(spi_sclk_o),
        .mosi_i(spi_mosi_o), .cs_n_i(spi_cs_n_o), .miso_o(spi_miso_i));

    // System clock
    initial forever #5 clk_sys_i = ~clk_sys_i;

    // Compare and report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // Queue one write byte; valid stays up so back-to-back pushes stream
    task automatic push(input logic [7:0] d);
        wr_data_i = d;
        wr_valid_i = 1;
        do @(posedge clk_sys_i); while (wr_ready_o !== 1'b1);
        #1;
    endtask : push

    // Place one order, collect read bytes, wait for the frame to end
    task automatic order(input cmd_kind_t k, input logic [7:0] a0, a1, a2,
                         input logic [15:0] ad, input logic [7:0] n);
        {cmd_kind_i, cmd_arg0_i, cmd_arg1_i, cmd_arg2_i} = {k, a0, a1, a2};
        {cmd_addr_i, cmd_len_i, cmd_valid_i} = {ad, n, 1'b1};
        do @(posedge clk_sys_i); while (cmd_ready_o !== 1'b1);
        refd = refused_o;
        #1 cmd_valid_i = 0;
        got.delete();
        if (refd !== 1'b1) do begin
            @(posedge clk_sys_i);
            if (rd_valid_o === 1'b1) got.push_back(rd_data_o);
        end while (done_o !== 1'b1);
        repeat (12) @(posedge clk_sys_i);
        #1;
    endtask : order

    // Verdict and end of run
    task automatic stop_test;
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // Watchdog: about 11 frames of under 1,200 cycles each, with margin
    initial begin
        #400_000;
        n_mismatch++;
        stop_test;
    end

    // Test sequence
    initial begin
        repeat (12) @(posedge clk_sys_i);
        #1 rst_i = 0;
        check(post_packet_state_o, 8'h20);
        foreach (codes[i]) begin
            order(KIND_POST_STATE, codes[i], 0, 0, 0, 0);
            check(dev.state, codes[i]);
            check(post_packet_state_o, codes[i]);
        end
        order(KIND_POST_STATE, 8'h10, 0, 0, 0, 0);
        check(refd, 1'b1);
        check(dev.state, 8'h30);
        order(KIND_IMAGE_CAL, 8'h6B, 8'h6F, 0, 0, 0);
        check({dev.par[0], dev.par[1]}, 16'h986B);
        check(dev.par[2], 8'h6F);
        order(KIND_AMP_SETUP, 8'h09, 8'h0A, 8'h00, 0, 0);
        check({dev.par[0], dev.par[1]}, 16'h9504);
        check({dev.par[2], dev.par[3]}, 16'h0700);
        check(dev.par[4], 8'h01);
        band_above_400_i = 1;
        order(KIND_AMP_SETUP, 8'h09, 8'h02, 8'h01, 0, 0);
        check({dev.par[1], dev.par[3]}, 16'h0701);
        band_above_400_i = 0;
        order(KIND_AMP_SETUP, 8'h09, 8'h02, 8'h01, 0, 0);
        check({dev.par[1], dev.par[4]}, 16'h0401);
        order(KIND_AMP_SETUP, 8'h02, 8'h02, 8'h02, 0, 0);
        check(refd, 1'b1);
        foreach (dat[i]) push(dat[i]);
        wr_valid_i = 0;
        order(KIND_MEM_WRITE, 0, 0, 0, 16'h12FF, 3);
        foreach (dat[i]) check(dev.mem[16'h12FF+i], dat[i]);
        check(next_addr_o, 16'h1302);
        order(KIND_MEM_READ, 0, 0, 0, 16'h12FF, 3);
        check(got.size(), 3);
        foreach (got[i]) check(got[i], dat[i]);
        check(next_addr_o, 16'h1302);
        check(status_o, STATUS);
        foreach (dat[i]) push(dat[i]);
        wr_valid_i = 0;
        order(KIND_PAYLOAD_STORE, 0, 0, 0, 16'h00FE, 3);
        foreach (dat[i]) check(dev.pay[(254+i)%256], dat[i]);
        check(next_addr_o, 16'h0001);
        order(KIND_PAYLOAD_FETCH, 0, 0, 0, 16'h00FE, 3);
        check(got.size(), 3);
        foreach (got[i]) check(got[i], dat[i]);
        check(next_addr_o, 16'h0001);
        stop_test;
    end
endmodule : radio_cmd_host_bench
